/* File: rtl/sda_pkg.sv */
// Package of constants and carrier types for the step attenuator control.
package sda_pkg;

   // ----------------------------------------------------------------------
   // Word format
   // ----------------------------------------------------------------------
   localparam int ATTEN_W = 5;
   localparam int TOP_BIT = 4;
   localparam int LSB_BIT = 0;

   // ----------------------------------------------------------------------
   // Synchroniser and power-up load timing
   // ----------------------------------------------------------------------
   localparam int SYNC_STAGES = 3;
   localparam logic [2:0] LOAD_LAST = 3'h4;

   // ----------------------------------------------------------------------
   // Register map, byte addresses within the slave
   // ----------------------------------------------------------------------
   localparam int REG_AW = 8;
   localparam logic [REG_AW-1:0] ADDR_CTRL = 8'h00;
   localparam logic [REG_AW-1:0] ADDR_STATUS = 8'h04;
   localparam int CTRL_OVR_BIT = 0;
   localparam int CTRL_CODE_LSB = 8;
   localparam int STAT_HELD_LSB = 0;
   localparam int STAT_SHIFT_LSB = 8;
   localparam int STAT_STROBE_BIT = 16;
   localparam int STAT_LOADED_BIT = 17;
   localparam int STAT_OVR_BIT = 18;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

   // ----------------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------------
   typedef logic [ATTEN_W-1:0] sda_code_type;

   // Attenuation bits, heaviest first so the struct packs as the code.
   typedef struct packed {
      logic b8db;
      logic b4db;
      logic b2db;
      logic b1db;
      logic b05db;
   } sda_atten_type;

   typedef enum logic {ST_LOAD, ST_RUN} sda_state_type;

   typedef struct packed {
      logic hsel;
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic [31:0] hwdata;
      logic hready;
   } sda_ahb_req_type;

   typedef struct packed {
      logic [31:0] hrdata;
      logic hreadyout;
      logic hresp;
   } sda_ahb_rsp_type;

endpackage

/* File: rtl/sda_serial_ctrl.sv */
// Serial control of a five-bit step attenuator with an AHB-Lite register port.
//
// Behaviour
// - The serial word that sets the attenuation is exactly five bits.
// - Word bit four drives the 8 dB step.
// - Word bit zero drives the 0.5 dB step, the finest one.
// - At power-up all five bits load from the parallel weight inputs.
// - Any of the 32 codes can be chosen as power-up state that way.
// - Data is sampled on the serial clock rising edge, set up before it.
// - While the strobe is high the shift contents drive the setting.
// - When the strobe falls the shift contents are held as setting.
// - Shifting goes on whatever the strobe level.
`timescale 1ns/1ps
module sda_serial_ctrl
   import sda_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire sda_ahb_req_type ahb_req,
   output sda_ahb_rsp_type ahb_rsp,
   input wire logic ser_clk,
   input wire logic ser_data,
   input wire logic latch_strobe,
   input wire sda_atten_type weight_in,
   output sda_atten_type atten_out
);

   // ----------------------------------------------------------------------
   // State types
   // ----------------------------------------------------------------------
   typedef struct packed {
      sda_code_type shift;
   } sda_link_state_type;

   typedef struct packed {
      sda_state_type st;
      logic [2:0] load_cnt;
      sda_code_type held;
      logic loaded;
      logic ovr;
      sda_code_type sw_code;
      sda_atten_type atten;
      logic wr_pend;
      logic [REG_AW-1:0] wr_addr;
      logic [31:0] hrdata;
   } sda_sys_state_type;

   localparam int SYNC_W = 2 * ATTEN_W + 1;

   sda_link_state_type lk_r;
   sda_link_state_type lk_nxt;
   sda_sys_state_type sy_r;
   sda_sys_state_type sy_nxt;
   logic [SYNC_W-1:0] sync_in;
   logic [SYNC_W-1:0] sync_q;
   sda_code_type shift_s;
   sda_code_type weight_s;
   logic strobe_s;
   logic acc;

   // ----------------------------------------------------------------------
   // Link domain: the shift register on the serial clock
   // ----------------------------------------------------------------------

   // Each rising edge moves the word up one place and takes the data pin
   // at the bottom, so the first bit sent ends at the top after five edges.
   always_comb
   begin
      lk_nxt = lk_r;
      lk_nxt.shift = {lk_r.shift[ATTEN_W-2:0], ser_data};
   end

   // The strobe plays no part here, so shifting never stalls on it.
   always_ff @(posedge ser_clk or posedge reset)
   begin
      if (reset)
      begin
         lk_r <= '0;
      end
      else
      begin
         lk_r <= lk_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // Crossing into the system clock
   // ----------------------------------------------------------------------

   // The shift word is quiet around a strobe pulse, because the serial
   // clock has stopped by then; each bit settles on its own and is taken
   // only once two stages agree, so a pulse never takes a word mid-change.
   assign sync_in = {weight_in, latch_strobe, lk_r.shift};

   sda_sync3 #(
      .W(SYNC_W)
   ) u_sync (
      .clk_sys(clk_sys),
      .reset(reset),
      .d_async(sync_in),
      .q(sync_q)
   );

   // Split the settled bits back into their fields.
   assign shift_s = sync_q[ATTEN_W-1:0];
   assign strobe_s = sync_q[ATTEN_W];
   assign weight_s = sync_q[SYNC_W-1:ATTEN_W+1];

   // An address phase is taken when the slave is selected and ready and the transfer is NONSEQ.
   assign acc = ahb_req.hsel && ahb_req.hready
      && (ahb_req.htrans == HTRANS_NONSEQ);

   // ----------------------------------------------------------------------
   // System domain: power-up load, latch and register port
   // ----------------------------------------------------------------------

   // Next state of the system side.
   always_comb
   begin
      sy_nxt = sy_r;
      case (sy_r.st)
         ST_LOAD:
         begin
            // Wait until the weight pins have passed the synchroniser,
            // then take all five as the opening setting.
            // The synchroniser clears on reset, so a set weight bit only
            // shows on its output at the fourth edge; loading earlier
            // would take zeros instead of the pins.
            if (sy_r.load_cnt == LOAD_LAST)
            begin
               sy_nxt.held = weight_s;
               sy_nxt.loaded = 1'b1;
               sy_nxt.st = ST_RUN;
            end
            else
            begin
               sy_nxt.load_cnt = sy_r.load_cnt + 3'h1;
            end
         end
         ST_RUN:
         begin
            // Transparent while the strobe is high, frozen once it is low.
            if (strobe_s)
            begin
               sy_nxt.held = shift_s;
            end
         end
         default:
         begin
            sy_nxt.st = ST_LOAD;
         end
      endcase

      // Write data phase of a transfer taken the cycle before.
      if (sy_r.wr_pend && (sy_r.wr_addr == ADDR_CTRL))
      begin
         sy_nxt.ovr = ahb_req.hwdata[CTRL_OVR_BIT];
         sy_nxt.sw_code = ahb_req.hwdata[CTRL_CODE_LSB +: ATTEN_W];
      end

      // Address phase: note writes, and fetch control read data from the values
      // just updated so a read right after a write sees the new word.
      sy_nxt.wr_pend = acc && ahb_req.hwrite;
      sy_nxt.wr_addr = ahb_req.haddr[REG_AW-1:0];
      if (acc && !ahb_req.hwrite)
      begin
         sy_nxt.hrdata = WORD_ZERO;
         if (ahb_req.haddr[REG_AW-1:0] == ADDR_CTRL)
         begin
            sy_nxt.hrdata[CTRL_OVR_BIT] = sy_nxt.ovr;
            sy_nxt.hrdata[CTRL_CODE_LSB +: ATTEN_W] = sy_nxt.sw_code;
         end
         else if (ahb_req.haddr[REG_AW-1:0] == ADDR_STATUS)
         begin
            sy_nxt.hrdata[STAT_HELD_LSB +: ATTEN_W] = sy_r.held;
            sy_nxt.hrdata[STAT_SHIFT_LSB +: ATTEN_W] = shift_s;
            sy_nxt.hrdata[STAT_STROBE_BIT] = strobe_s;
            sy_nxt.hrdata[STAT_LOADED_BIT] = sy_r.loaded;
            sy_nxt.hrdata[STAT_OVR_BIT] = sy_r.ovr;
         end
      end

      // Drive the five weighted bits, heaviest bit to the 8 dB step.
      if (sy_r.ovr)
      begin
         sy_nxt.atten = sda_atten_type'(sy_r.sw_code);
      end
      else
      begin
         sy_nxt.atten = sda_atten_type'(sy_r.held);
      end
   end

   // State register of the system side.
   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         sy_r <= '0;
      end
      else
      begin
         sy_r <= sy_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------

   // Zero wait states and an OKAY answer on every transfer.
   assign ahb_rsp.hrdata = sy_r.hrdata;
   assign ahb_rsp.hreadyout = 1'b1;
   assign ahb_rsp.hresp = 1'b0;
   assign atten_out = sy_r.atten;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------

   sequence s_load_done;
      (sy_r.st == ST_LOAD) && (sy_r.load_cnt == LOAD_LAST);
   endsequence

   sequence s_strobe_open;
      (sy_r.st == ST_RUN) && strobe_s;
   endsequence

   sequence s_load_wait;
      (sy_r.st == ST_LOAD) && (sy_r.load_cnt != LOAD_LAST);
   endsequence

   // Each serial edge takes the data pin into the bottom place.
   a_shift_sample: assert property (
      @(posedge ser_clk) disable iff (reset)
      1'b1 |=> lk_r.shift == {$past(lk_r.shift[ATTEN_W-2:0]), $past(ser_data)})
      else $error("Shift register did not take the data pin.");

   // A bit reaches the top place exactly four edges after the edge that took it.
   a_word_five: assert property (
      @(posedge ser_clk) disable iff (reset)
      1'b1 |-> ##5 lk_r.shift[TOP_BIT] == $past(ser_data, 5))
      else $error("Word length through the shift register is not five.");

   // The power-up load takes the synchronised weights whole.
   a_powerup_load: assert property (
      @(posedge clk_sys) disable iff (reset)
      s_load_done |=> sy_r.loaded && (sy_r.held == $past(weight_s)))
      else $error("Power-up setting differs from the weight inputs.");

   // The load finishes within five cycles of leaving reset.
   a_load_bounded: assert property (
      @(posedge clk_sys) disable iff (reset)
      (sy_r.st == ST_LOAD) |-> ##[1:5] (sy_r.st == ST_RUN))
      else $error("Power-up load did not finish in time.");

   // While the strobe is high the setting follows the shift word.
   a_strobe_pass: assert property (
      @(posedge clk_sys) disable iff (reset)
      s_strobe_open |=> sy_r.held == $past(shift_s))
      else $error("Open latch did not pass the shift word.");

   // With the strobe low the setting holds for as long as it stays low.
   a_latch_hold: assert property (
      @(posedge clk_sys) disable iff (reset)
      ((sy_r.st == ST_RUN) && !strobe_s) [*2] |-> $stable(sy_r.held))
      else $error("Closed latch changed its setting.");

   // The top word bit appears on the 8 dB output one cycle later.
   a_top_bit: assert property (
      @(posedge clk_sys) disable iff (reset)
      !sy_r.ovr |=> atten_out.b8db == $past(sy_r.held[TOP_BIT]))
      else $error("8 dB output does not follow word bit four.");

   // The bottom word bit appears on the 0.5 dB output one cycle later.
   a_lsb_bit: assert property (
      @(posedge clk_sys) disable iff (reset)
      !sy_r.ovr |=> atten_out.b05db == $past(sy_r.held[LSB_BIT]))
      else $error("0.5 dB output does not follow word bit zero.");

   // The weights are not taken before the synchroniser has settled them.
   a_load_wait: assert property (
      @(posedge clk_sys) disable iff (reset)
      s_load_wait |=> (sy_r.st == ST_LOAD) && !sy_r.loaded)
      else $error("Power-up load taken before the weights settled.");

   // Once loaded the block stays in normal running until the next reset.
   a_load_once: assert property (
      @(posedge clk_sys) disable iff (reset)
      (sy_r.st == ST_RUN) |=> (sy_r.st == ST_RUN) && sy_r.loaded)
      else $error("Power-up load state was entered again.");

   // With the override set the software code drives the outputs.
   a_override_code: assert property (
      @(posedge clk_sys) disable iff (reset)
      sy_r.ovr |=> atten_out == sda_atten_type'($past(sy_r.sw_code)))
      else $error("Override code does not reach the outputs.");

   // A write data phase to the control word lands the next cycle.
   a_write_ctrl: assert property (
      @(posedge clk_sys) disable iff (reset)
      sy_r.wr_pend && (sy_r.wr_addr == ADDR_CTRL)
         |=> sy_r.ovr == $past(ahb_req.hwdata[CTRL_OVR_BIT]))
      else $error("Control write did not land.");

endmodule

/* File: rtl/sda_sync3.sv */
// Three-stage synchroniser bank that updates a bit once stages two and three agree.
`timescale 1ns/1ps
module sda_sync3
   import sda_pkg::*;
#(
   parameter int W = 11
)
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [W-1:0] d_async,
   output logic [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } sda_sync_state_type;

   sda_sync_state_type st_r;
   sda_sync_state_type st_nxt;
   logic [W-1:0] agree;

   // Per bit, the settled value is accepted only when the last two agree.
   for (genvar i = 0; i < W; i++)
   begin : g_bit
      assign agree[i] = (st_r.s2[i] == st_r.s3[i]);
   end

   // The first stage feeds only the second stage.
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.s1 = d_async;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      st_nxt.q = (st_r.s3 & agree) | (st_r.q & ~agree);
   end

   // State register.
   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign q = st_r.q;

endmodule

/* File: test/sda_ctrl_model.sv */
// Behavioural model of the external controller that programs the attenuator.
`timescale 1ns/1ps
module sda_ctrl_model
(
   output logic ser_clk,
   output logic ser_data,
   output logic latch_strobe
);
   // The serial clock stands still low and the strobe is low between frames.
   initial
   begin
      ser_clk = 1'b0;
      ser_data = 1'b0;
      latch_strobe = 1'b0;
   end

   // Shifts the low n bits of w, heaviest bit first, one bit per period.
   task automatic shift_bits(input logic [7:0] w, input int n, input int half);
      #13;
      for (int i = n - 1; i >= 0; i--)
      begin
         ser_data = w[i];
         #(half) ser_clk = 1'b1;
         #(half) ser_clk = 1'b0;
      end
      // A released data line shows the inverse so a stale bit is never used.
      ser_data = ~ser_data;
   endtask

   // Pulses the strobe once after the last falling clock edge of a word,
   // keeping the word quiet around it for the slow strobe sampling.
   task automatic pulse_strobe(input int width);
      #400 latch_strobe = 1'b1;
      #(width) latch_strobe = 1'b0;
      #400;
   endtask

   // Sets the strobe level directly, for shifting with the latch open.
   // The change lands off the system clock edge.
   task automatic set_strobe(input logic v);
      #7 latch_strobe = v;
   endtask
endmodule

/* File: test/testbench.sv */
// Self-checking testbench for the serial attenuator control block.
`timescale 1ns/1ps
module testbench
   import sda_pkg::*;
;
   logic clk_sys;
   logic reset;
   sda_ahb_req_type req;
   sda_ahb_req_type req_w;
   sda_ahb_rsp_type rsp;
   logic ser_clk;
   logic ser_data;
   logic latch_strobe;
   sda_atten_type weight_in;
   sda_atten_type atten_out;
   logic [31:0] rd;
   logic [4:0] pups [4] = '{5'h00, 5'h15, 5'h0A, 5'h1F};
   int failures;
   int n_compared;

   // The single slave's ready output is the bus ready.
   assign req_w = {req[$bits(sda_ahb_req_type)-1:1], rsp.hreadyout};

   sda_serial_ctrl uut
   (
      .clk_sys(clk_sys),
      .reset(reset),
      .ahb_req(req_w),
      .ahb_rsp(rsp),
      .ser_clk(ser_clk),
      .ser_data(ser_data),
      .latch_strobe(latch_strobe),
      .weight_in(weight_in),
      .atten_out(atten_out)
   );

   sda_ctrl_model host
   (
      .ser_clk(ser_clk),
      .ser_data(ser_data),
      .latch_strobe(latch_strobe)
   );

   // ----------------------------------------------------------------------
   // Clock, tasks and checks
   // ----------------------------------------------------------------------
   // System clock of 100 ns period.
   initial
   begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   // Waits for a rising edge at which the slave shows ready.
   task automatic wait_ready();
      @(posedge clk_sys);
      while (rsp.hreadyout !== 1'b1)
         @(posedge clk_sys);
   endtask

   // One single word transfer: address phase, then data phase.
   task automatic ahb_xfer(input logic [7:0] a, input logic wr,
      input logic [31:0] wd, output logic [31:0] rdat);
      req.hsel <= 1'b1;
      req.haddr <= {24'h000000, a};
      req.htrans <= HTRANS_NONSEQ;
      req.hwrite <= wr;
      req.hsize <= 3'h2;
      wait_ready();
      req.htrans <= 2'h0;
      req.hsel <= 1'b0;
      req.hwdata <= wd;
      wait_ready();
      rdat = rsp.hrdata;
      check_word({31'h0000_0000, rsp.hresp}, WORD_ZERO);
   endtask

   task automatic check_code(input sda_atten_type got, input logic [4:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         failures++;
         $display("unexpected code at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         failures++;
         $display("unexpected word at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Applies a power-up with the given weight pins and checks the result.
   task automatic power_up(input logic [4:0] code);
      weight_in <= code;
      reset <= 1'b1;
      tick(5);
      check_code(atten_out, 5'h00);
      reset <= 1'b0;
      tick(8);
      check_code(atten_out, code);
      ahb_xfer(ADDR_STATUS, 1'b0, WORD_ZERO, rd);
      check_word(rd, 32'h0002_0000 | code);
   endtask

   task automatic finish_test();
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   // Power-up loads, serial words, latch behaviour, then the register port.
   initial
   begin
      reset = 1'b1;
      req = '0;
      weight_in = '0;
      failures = 0;
      n_compared = 0;
      foreach (pups[i])
         power_up(pups[i]);
      host.shift_bits(8'h10, 5, 40);
      host.pulse_strobe(1000);
      tick(8);
      check_code(atten_out, 5'h10);
      host.shift_bits(8'h21, 6, 40);
      host.pulse_strobe(500);
      tick(8);
      check_code(atten_out, 5'h01);
      host.shift_bits(8'h16, 5, 40);
      tick(8);
      check_code(atten_out, 5'h01);
      ahb_xfer(ADDR_STATUS, 1'b0, WORD_ZERO, rd);
      check_word(rd, 32'h0002_1601);
      host.set_strobe(1'b1);
      tick(8);
      check_code(atten_out, 5'h16);
      host.shift_bits(8'h09, 5, 40);
      tick(8);
      check_code(atten_out, 5'h09);
      host.set_strobe(1'b0);
      tick(8);
      host.shift_bits(8'h1F, 5, 40);
      tick(8);
      check_code(atten_out, 5'h09);
      ahb_xfer(ADDR_CTRL, 1'b1, 32'h0000_0C01, rd);
      ahb_xfer(ADDR_CTRL, 1'b0, WORD_ZERO, rd);
      check_word(rd, 32'h0000_0C01);
      tick(3);
      check_code(atten_out, 5'h0C);
      ahb_xfer(ADDR_STATUS, 1'b0, WORD_ZERO, rd);
      check_word(rd, 32'h0006_1F09);
      ahb_xfer(8'h10, 1'b1, 32'hFFFF_FFFF, rd);
      ahb_xfer(8'h10, 1'b0, WORD_ZERO, rd);
      check_word(rd, WORD_ZERO);
      ahb_xfer(ADDR_CTRL, 1'b1, WORD_ZERO, rd);
      tick(3);
      check_code(atten_out, 5'h09);
      finish_test();
   end

   // Cuts a hang short well after the sequence should have ended.
   initial
   begin
      #200000;
      failures++;
      finish_test();
   end
endmodule
